// ---- logic/mpp_port.sv ----
// Bus port: burst initiator for the DMA engine and three-area target.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Address and command are valid in the first clock FRAME is asserted.
// - Reads leave one turnaround; target drives data only after DEVSEL.
// - As target, TRDY is never asserted before DEVSEL.
// - Target read data is valid no earlier than two clocks after address.
// - Target data drivers stay on until the read transaction ends.
// - A word moves only when IRDY and TRDY are both asserted.
// - As initiator, FRAME drops only together with IRDY for the last phase.
// - Writes need no turnaround; data follows the address at once.
// - Initiator write wait keeps data but withdraws byte enables.
// - Last phase is IRDY with FRAME off; it ends when TRDY comes.
// - Unchained DMA memory bursts, and the first of a chain, run with zero initiator wait states.
// - Chained fast bursts: one wait on first data of later transactions.
// - As target, wait cycles are made by holding TRDY off.
// - Target waits: config read 2, register/local read 3, writes 0.
// - Local bus reads also wait for the peripheral's local ready.
// - DMA traffic to host memory always uses burst transactions.
// - Target decodes config space, on-chip registers and local bus.
// - In demultiplexed configuration parity is driven constantly low.
module mpp_port #(
  parameter int unsigned DEPTH = mpp_pkg::FIFO_DEPTH,
  parameter int unsigned LW    = mpp_pkg::LEN_W
) (
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  // Bus pins
  input  wire logic [31:0]   ad_i,
  output logic [31:0]        ad_o,
  output logic               ad_oe_o,
  input  wire logic [3:0]    cbe_n_i,
  output logic [3:0]         cbe_n_o,
  output logic               cbe_oe_o,
  input  wire logic          frame_n_i,
  output logic               frame_n_o,
  output logic               frame_oe_o,
  input  wire logic          irdy_n_i,
  output logic               irdy_n_o,
  output logic               irdy_oe_o,
  input  wire logic          trdy_n_i,
  output logic               trdy_n_o,
  output logic               trdy_oe_o,
  input  wire logic          devsel_n_i,
  output logic               devsel_n_o,
  output logic               devsel_oe_o,
  input  wire logic          idsel_i,
  output logic               par_o,
  output logic               par_oe_o,
  output logic               req_n_o,
  input  wire logic          gnt_n_i,
  input  wire logic          demux_mode_i,
  // DMA engine
  input  wire logic          dma_req_i,
  input  wire logic          dma_write_i,
  input  wire logic          dma_fbb_i,
  input  wire logic [31:0]   dma_addr_i,
  input  wire logic [LW-1:0] dma_len_i,
  output logic               dma_ack_o,
  input  wire logic [31:0]   dma_wdata_i,
  input  wire logic          dma_wvalid_i,
  output logic               dma_wready_o,
  output logic [31:0]        dma_rdata_o,
  output logic               dma_rvalid_o,
  // Target user side
  output logic               tgt_rd_o,
  output logic               tgt_wr_o,
  output logic [1:0]         tgt_area_o,
  output logic [31:0]        tgt_addr_o,
  output logic [31:0]        tgt_wdata_o,
  output logic [3:0]         tgt_be_n_o,
  input  wire logic [31:0]   tgt_rdata_i,
  input  wire logic          local_ready_n_i
);
  initial begin
    if (LW < 2 || (2 ** LW) <= DEPTH) begin
      $error("Length width must cover the buffer depth");
    end
  end

  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_WAIT, M_DATA, M_END} mpp_m_t;
  typedef enum logic [1:0] {T_IDLE, T_DATA, T_END} mpp_t_t;

  mpp_m_t                  m_state;
  mpp_t_t                  t_state;
  logic [31:0]             m_ad;
  logic [LW-1:0]           m_cnt;
  logic                    m_write;
  logic                    m_wait1;
  logic [31:0]             t_ad;
  logic [1:0]              t_wait;
  logic                    t_write;
  logic                    t_drive;
  logic                    frame_prev;
  logic [$clog2(DEPTH):0]  fifo_cnt;
  logic                    xfer;
  logic                    m_go_ok;
  logic                    m_want;
  logic                    m_start;
  logic                    m_chain;
  logic                    m_own;
  logic                    t_hit;
  logic [1:0]              t_hit_area;
  logic                    t_ready;
  logic                    t_last;

  mpp_stream_if #(.W(32)) wr_s ();
  mpp_stream_if #(.W(32)) rd_s ();

  assign wr_s.valid   = dma_wvalid_i;
  assign wr_s.data    = dma_wdata_i;
  assign dma_wready_o = wr_s.ready;

  mpp_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .wr        (wr_s),
    .rd        (rd_s),
    .count_o   (fifo_cnt)
  );

  // ****************************************************************
  // Initiator
  // ****************************************************************
  assign xfer = !irdy_n_i && !trdy_n_i;
  // A write burst starts only with its whole payload buffered, so the
  // initiator never has to pause for data in mid-burst.
  assign m_want = dma_req_i && (!dma_write_i ||
    LW'(fifo_cnt) >= dma_len_i);
  assign m_go_ok = m_want && !gnt_n_i;
  assign m_start = m_state == M_IDLE && m_go_ok && t_state == T_IDLE &&
    frame_n_i && irdy_n_i;
  assign m_chain = m_state == M_DATA && xfer && m_cnt == LW'(1) &&
    m_go_ok && dma_fbb_i;
  assign m_own = m_state != M_IDLE;
  assign req_n_o = !(m_own || m_want);
  assign dma_ack_o = m_start || m_chain;
  assign rd_s.ready = m_write && (m_state == M_ADDR ||
    (m_state == M_DATA && xfer && m_cnt != LW'(1)));

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_state <= M_IDLE;
      m_cnt   <= '0;
      m_write <= 1'b0;
      m_wait1 <= 1'b0;
    end else begin
      case (m_state)
        M_IDLE: begin
          if (m_start) begin
            m_state <= M_ADDR;
            m_cnt   <= dma_len_i;
            m_write <= dma_write_i;
            m_wait1 <= 1'b0;
          end
        end
        M_ADDR: begin
          m_state <= m_wait1 ? M_WAIT : M_DATA;
        end
        M_WAIT: begin
          m_state <= M_DATA;
        end
        M_DATA: begin
          if (xfer) begin
            if (m_cnt != LW'(1)) begin
              m_cnt <= m_cnt - 1'b1;
            end else if (m_chain) begin
              m_state <= M_ADDR;
              m_cnt   <= dma_len_i;
              m_write <= dma_write_i;
              m_wait1 <= 1'b1;
            end else begin
              m_state <= M_END;
            end
          end
        end
        M_END: begin
          m_state <= M_IDLE;
        end
        default: begin
          m_state <= M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_ad <= '0;
    end else if (m_start || m_chain) begin
      m_ad <= dma_addr_i;
    end else if (rd_s.ready) begin
      m_ad <= rd_s.data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_rdata_o  <= '0;
      dma_rvalid_o <= 1'b0;
    end else begin
      dma_rvalid_o <= m_state == M_DATA && !m_write && xfer;
      if (m_state == M_DATA && !m_write && xfer) begin
        dma_rdata_o <= ad_i;
      end
    end
  end

  // ****************************************************************
  // Target
  // ****************************************************************
  always_comb begin
    t_hit_area = mpp_pkg::AREA_CFG;
    t_hit      = 1'b0;
    if (idsel_i && (cbe_n_i == mpp_pkg::CMD_CFG_RD ||
        cbe_n_i == mpp_pkg::CMD_CFG_WR)) begin
      t_hit = 1'b1;
    end else if (cbe_n_i == mpp_pkg::CMD_MEM_RD ||
        cbe_n_i == mpp_pkg::CMD_MEM_WR) begin
      if (ad_i[31:mpp_pkg::REG_WIN_BITS] ==
          mpp_pkg::REG_BASE[31:mpp_pkg::REG_WIN_BITS]) begin
        t_hit      = 1'b1;
        t_hit_area = mpp_pkg::AREA_REG;
      end else if (ad_i[31:mpp_pkg::LB_WIN_BITS] ==
          mpp_pkg::LB_BASE[31:mpp_pkg::LB_WIN_BITS]) begin
        t_hit      = 1'b1;
        t_hit_area = mpp_pkg::AREA_LB;
      end
    end
    t_hit = t_hit && !frame_n_i && frame_prev && t_state == T_IDLE &&
      !m_own;
  end

  // Local bus reads stretch until the peripheral reports ready.
  assign t_ready = t_state == T_DATA && t_wait == 2'h0 && (t_write ||
    tgt_area_o != mpp_pkg::AREA_LB || !local_ready_n_i);
  assign t_last = frame_n_i;
  assign tgt_rd_o = t_state == T_DATA && !t_write;

  function automatic logic [1:0] rd_wait(input logic [1:0] area);
    rd_wait = (area == mpp_pkg::AREA_CFG) ? mpp_pkg::WAIT_CFG_RD :
      (area == mpp_pkg::AREA_REG) ? mpp_pkg::WAIT_REG_RD :
      mpp_pkg::WAIT_LB_RD;
  endfunction

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t_state    <= T_IDLE;
      t_wait     <= '0;
      t_write    <= 1'b0;
      t_drive    <= 1'b0;
      tgt_area_o <= '0;
      tgt_addr_o <= '0;
      frame_prev <= 1'b1;
    end else begin
      frame_prev <= frame_n_i;
      case (t_state)
        T_IDLE: begin
          if (t_hit) begin
            t_state    <= T_DATA;
            t_write    <= cbe_n_i[0];
            tgt_area_o <= t_hit_area;
            tgt_addr_o <= ad_i;
            t_wait     <= cbe_n_i[0] ? mpp_pkg::WAIT_WR :
              rd_wait(t_hit_area);
          end
        end
        T_DATA: begin
          t_drive <= !t_write;
          if (t_wait != 2'h0) begin
            t_wait <= t_wait - 1'b1;
          end else if (t_ready && !irdy_n_i) begin
            if (t_last) begin
              t_state <= T_END;
            end else begin
              tgt_addr_o <= tgt_addr_o + mpp_pkg::WORD_STEP;
              t_wait     <= t_write ? mpp_pkg::WAIT_WR :
                rd_wait(tgt_area_o);
            end
          end
        end
        T_END: begin
          t_state <= T_IDLE;
          t_drive <= 1'b0;
        end
        default: begin
          t_state <= T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t_ad        <= '0;
      tgt_wr_o    <= 1'b0;
      tgt_wdata_o <= '0;
      tgt_be_n_o  <= mpp_pkg::BE_NONE;
    end else begin
      if (t_state == T_DATA && !t_write && t_wait <= 2'h1) begin
        t_ad <= tgt_rdata_i;
      end
      tgt_wr_o <= t_state == T_DATA && t_write && t_ready && !irdy_n_i;
      if (t_state == T_DATA && t_write && t_ready && !irdy_n_i) begin
        tgt_wdata_o <= ad_i;
        tgt_be_n_o  <= cbe_n_i;
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_comb begin
    cbe_n_o = mpp_pkg::BE_ALL;
    if (m_state == M_ADDR) begin
      cbe_n_o = m_write ? mpp_pkg::CMD_MEM_WR : mpp_pkg::CMD_MEM_RD;
    end else if (m_state == M_WAIT && m_write) begin
      cbe_n_o = mpp_pkg::BE_NONE;
    end
  end

  assign ad_oe_o = m_state == M_ADDR ||
    (m_write && (m_state == M_WAIT || m_state == M_DATA)) ||
    (t_state == T_DATA && t_drive);
  assign ad_o = m_own ? m_ad : t_ad;
  assign cbe_oe_o = m_own && m_state != M_END;
  assign frame_oe_o = m_own;
  assign frame_n_o = !(m_state == M_ADDR || m_state == M_WAIT ||
    (m_state == M_DATA && m_cnt != LW'(1)));
  assign irdy_oe_o = m_own && m_state != M_ADDR;
  assign irdy_n_o = m_state != M_DATA;
  assign devsel_oe_o = t_state != T_IDLE;
  assign devsel_n_o = t_state != T_DATA;
  assign trdy_oe_o = t_state != T_IDLE;
  assign trdy_n_o = !t_ready;

  logic par_q;
  logic par_en;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      par_q  <= 1'b0;
      par_en <= 1'b0;
    end else begin
      par_q  <= ^{ad_o, cbe_n_o};
      par_en <= ad_oe_o;
    end
  end
  assign par_o = demux_mode_i ? 1'b0 : par_q;
  assign par_oe_o = demux_mode_i || par_en;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_addr_phase_valid: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    m_state == M_ADDR |-> ad_oe_o && cbe_oe_o && !frame_n_o &&
      cbe_n_o[3:1] == 3'h3)
    else $error("Address phase lacks address or command");
  a_read_turnaround: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    m_state == M_ADDR && !m_write |=> !ad_oe_o)
    else $error("Initiator kept data lines on a read");
  a_trdy_needs_devsel: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !trdy_n_o |-> !devsel_n_o && devsel_oe_o)
    else $error("TRDY asserted without DEVSEL");
  a_tgt_read_late: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    t_hit && !cbe_n_i[0] |=> !ad_oe_o && trdy_n_o)
    else $error("Target read data came too early");
  a_tgt_drive_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    t_state == T_DATA && t_drive |=> t_state == T_END || ad_oe_o)
    else $error("Target released data lines mid read");
  a_frame_drop: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    frame_oe_o && $rose(frame_n_o) && m_state == M_DATA |-> !irdy_n_o)
    else $error("FRAME dropped without IRDY");
  a_zero_wait: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    m_state == M_ADDR && !m_wait1 |=> !irdy_n_o)
    else $error("Initiator inserted a wait state");
  a_fbb_one_wait: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    m_state == M_ADDR && m_wait1 |=> irdy_n_o ##1 !irdy_n_o)
    else $error("Chained burst wait count wrong");
  a_be_withdraw: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    m_state == M_WAIT && m_write |-> ad_oe_o && cbe_n_o == 4'hf)
    else $error("Byte enables not withdrawn in write wait");
  a_cfg_read_wait: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    t_hit && cbe_n_i == 4'ha |=> trdy_n_o [*2] ##1 !trdy_n_o)
    else $error("Config read wait count wrong");
  a_reg_read_wait: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    t_hit && cbe_n_i == 4'h6 && t_hit_area == 2'h1
      |=> trdy_n_o [*3] ##1 !trdy_n_o)
    else $error("Register read wait count wrong");
  a_write_no_wait: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    t_hit && cbe_n_i[0] |=> !trdy_n_o && !devsel_n_o)
    else $error("Target write was not zero wait");
  a_idle_float: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !m_own && t_state == T_IDLE |-> !ad_oe_o && !frame_oe_o &&
      !trdy_oe_o && !irdy_oe_o)
    else $error("Outputs driven while idle");
  a_par_low: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    demux_mode_i |-> par_oe_o && !par_o)
    else $error("Parity not held low in demux mode");
endmodule
`default_nettype wire

// ---- logic/mpp_pkg.sv ----
// Constants shared by the bus port and its write-data buffer.
package mpp_pkg;
  // Bus commands on the command/byte-enable lines.
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] BE_ALL     = 4'h0;
  localparam logic [3:0] BE_NONE    = 4'hf;
  // Target wait states per access type.
  localparam logic [1:0] WAIT_CFG_RD = 2'h2;
  localparam logic [1:0] WAIT_REG_RD = 2'h3;
  localparam logic [1:0] WAIT_LB_RD  = 2'h3;
  localparam logic [1:0] WAIT_WR     = 2'h0;
  // Decoded target areas.
  localparam logic [1:0] AREA_CFG = 2'h0;
  localparam logic [1:0] AREA_REG = 2'h1;
  localparam logic [1:0] AREA_LB  = 2'h2;
  // Memory windows: upper address bits compared against a base.
  localparam int unsigned REG_WIN_BITS = 12;
  localparam int unsigned LB_WIN_BITS  = 16;
  localparam logic [31:0] REG_BASE = 32'h0000_0000;
  localparam logic [31:0] LB_BASE  = 32'h0001_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // Write buffer shape.
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LEN_W      = 8;
endpackage

// ---- logic/mpp_stream_if.sv ----
// Valid/ready word stream between the port and its buffer.
`timescale 1ns/1ps
`default_nettype none
interface mpp_stream_if #(
  parameter int unsigned W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- logic/mpp_fifo.sv ----
// Write-data FIFO with a fill count for burst admission.
`timescale 1ns/1ps
`default_nettype none
module mpp_fifo #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // Streams
  mpp_stream_if.snk             wr,
  mpp_stream_if.src             rd,
  // Fill level
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("FIFO depth must be a power of two of at least 2");
    end
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data  = mem[rd_ptr];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;
  assign count_o  = cnt;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/mpp_host.sv ----
// Host side model: memory target for bursts and CPU initiator.
`timescale 1ns/1ps
`default_nettype none
module mpp_host (
  // Clock, reset and target pace
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  slow_i,
  // Bus levels
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_n_i,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic        trdy_n_i,
  // Bus drives
  output logic [31:0]      ad_o,
  output logic             ad_oe_o,
  output logic [3:0]       cbe_n_o,
  output logic             mst_oe_o,
  output logic             frame_n_o,
  output logic             irdy_n_o,
  output logic             trdy_n_o,
  output logic             devsel_n_o,
  output logic             tgt_oe_o,
  output logic             idsel_o
);
  logic [31:0] wr_q[$];
  logic [3:0]  be_q[$];
  int          mw_q[$];
  logic [31:0] d;
  logic [31:0] mem_word;
  logic [3:0]  c;
  logic        f;
  logic        i;
  logic        t;
  logic        fr_d;
  logic        claim;
  logic        rd;
  int          wcnt;
  int          mw;
  initial begin
    {ad_oe_o, mst_oe_o, tgt_oe_o, idsel_o, claim, rd} = '0;
    {frame_n_o, irdy_n_o, trdy_n_o, devsel_n_o, fr_d} = '1;
    ad_o = '0;
    cbe_n_o = '0;
  end
  // Inputs are sampled at the edge, drives change just after it.
  always @(posedge ref_clk_i) begin
    {f, i, t, d, c} = {frame_n_i, irdy_n_i, trdy_n_i, ad_i, cbe_n_i};
    #1;
    if (!claim) begin
      tgt_oe_o = 0;
      if (!rst_i && fr_d && !f && !mst_oe_o && c[3:1] == 3'h3) begin
        claim = 1;
        rd = !c[0];
        mw = 0;
        mem_word = d ^ 32'h5a5a_0000;
        wcnt = slow_i + rd;
        tgt_oe_o = 1;
        devsel_n_o = 0;
        trdy_n_o = wcnt != 0;
      end
    end else if (!i && !t) begin
      if (rd) begin
        mem_word = mem_word + 1;
        ad_o = mem_word;
      end else begin
        wr_q.push_back(d);
        be_q.push_back(c);
      end
      if (f) begin
        claim = 0;
        devsel_n_o = 1;
        trdy_n_o = 1;
        ad_oe_o = 0;
        mw_q.push_back(mw);
      end else begin
        wcnt = slow_i;
        trdy_n_o = wcnt != 0;
      end
    end else begin
      if (i) mw++;
      ad_oe_o = rd;
      ad_o = mem_word;
      if (wcnt > 0) wcnt--;
      trdy_n_o = wcnt != 0;
    end
    fr_d = f;
  end
  // Single-phase access; waits is 99 when no target claims it.
  task automatic cpu(input logic [3:0] cmd, input logic [31:0] addr,
                     input logic sel, output logic [31:0] rdata,
                     output int waits);
    int n;
    mst_oe_o = 1;
    ad_oe_o = 1;
    frame_n_o = 0;
    irdy_n_o = 1;
    ad_o = addr;
    cbe_n_o = cmd;
    idsel_o = sel;
    @(posedge ref_clk_i) #1;
    frame_n_o = 1;
    irdy_n_o = 0;
    cbe_n_o = 4'h0;
    idsel_o = 0;
    ad_oe_o = cmd[0];
    ad_o = ~addr;
    waits = 99;
    rdata = '0;
    for (n = 0; n < 12; n++) begin
      @(posedge ref_clk_i);
      if (trdy_n_i === 1'b0) begin
        waits = n;
        rdata = ad_i;
        break;
      end
    end
    #1 irdy_n_o = 1;
    ad_oe_o = 0;
    @(posedge ref_clk_i) #1 mst_oe_o = 0;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the bus port facing a host model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i = 0;
  logic rst_i = 1;
  // A 33.33 MHz bus clock sits inside every allowed range.
  always #15 ref_clk_i = ~ref_clk_i;
  logic [31:0] p_ad, h_ad, ad_w, rdata_d, tgt_addr, tgt_wdata, wd, rdata;
  logic [31:0] ad_last = 0, dma_addr = 0, wdata = 0, rq[$];
  logic [3:0] p_cbe, h_cbe, cbe_w, tgt_be, wbe, cbe_last = 0;
  logic p_ad_oe, p_cbe_oe, p_fr, p_fr_oe, p_ir, p_ir_oe, p_tr, p_tr_oe;
  logic p_dv, p_dv_oe, h_ad_oe, h_moe, h_fr, h_ir, h_tr, h_dv, h_toe;
  logic h_sel, par, par_oe, req_n, ack, wready, rvalid, tgt_wr, gnt_n = 1;
  logic dma_req = 0, dma_write = 0, dma_fbb = 0, wvalid = 0, demux = 0;
  logic local_ready_n_n = 0, par_bad = 0, rd_seen = 0, tgt_rd;
  logic [1:0] area, warea, slow = 0;
  logic [7:0] dma_len = 1;
  int err_total = 0, check_count = 0, cyc = 0, w;
  // An undriven AD or C/BE line shows the inverse of its last level; undriven control lines read high.
  assign ad_w = p_ad_oe ? p_ad : h_ad_oe ? h_ad : ~ad_last;
  assign cbe_w = p_cbe_oe ? p_cbe : h_moe ? h_cbe : ~cbe_last;
  wire logic fr_w = p_fr_oe ? p_fr : h_moe ? h_fr : 1'b1;
  wire logic ir_w = p_ir_oe ? p_ir : h_moe ? h_ir : 1'b1;
  wire logic tr_w = p_tr_oe ? p_tr : h_toe ? h_tr : 1'b1;
  wire logic dv_w = p_dv_oe ? p_dv : h_toe ? h_dv : 1'b1;
  wire logic [31:0] tgt_rdata = {16'h5eed, tgt_addr[15:0]};
  mpp_host u_host (.ref_clk_i, .rst_i, .slow_i(slow), .ad_i(ad_w),
    .cbe_n_i(cbe_w), .frame_n_i(fr_w), .irdy_n_i(ir_w), .trdy_n_i(tr_w),
    .ad_o(h_ad), .ad_oe_o(h_ad_oe), .cbe_n_o(h_cbe), .mst_oe_o(h_moe),
    .frame_n_o(h_fr), .irdy_n_o(h_ir), .trdy_n_o(h_tr),
    .devsel_n_o(h_dv), .tgt_oe_o(h_toe), .idsel_o(h_sel));
  mpp_port u_port (.ref_clk_i, .rst_i, .ad_i(ad_w), .ad_o(p_ad),
    .ad_oe_o(p_ad_oe), .cbe_n_i(cbe_w), .cbe_n_o(p_cbe),
    .cbe_oe_o(p_cbe_oe), .frame_n_i(fr_w), .frame_n_o(p_fr),
    .frame_oe_o(p_fr_oe), .irdy_n_i(ir_w), .irdy_n_o(p_ir),
    .irdy_oe_o(p_ir_oe), .trdy_n_i(tr_w), .trdy_n_o(p_tr),
    .trdy_oe_o(p_tr_oe), .devsel_n_i(dv_w), .devsel_n_o(p_dv),
    .devsel_oe_o(p_dv_oe), .idsel_i(h_sel), .par_o(par), .par_oe_o(par_oe),
    .req_n_o(req_n), .gnt_n_i(gnt_n), .demux_mode_i(demux),
    .dma_req_i(dma_req), .dma_write_i(dma_write), .dma_fbb_i(dma_fbb),
    .dma_addr_i(dma_addr), .dma_len_i(dma_len), .dma_ack_o(ack),
    .dma_wdata_i(wdata), .dma_wvalid_i(wvalid), .dma_wready_o(wready),
    .dma_rdata_o(rdata_d), .dma_rvalid_o(rvalid), .tgt_rd_o(tgt_rd),
    .tgt_wr_o(tgt_wr), .tgt_area_o(area), .tgt_addr_o(tgt_addr),
    .tgt_wdata_o(tgt_wdata), .tgt_be_n_o(tgt_be), .tgt_rdata_i(tgt_rdata),
    .local_ready_n_i(local_ready_n_n));
  always @(posedge ref_clk_i) begin
    ad_last <= ad_w;
    cbe_last <= cbe_w;
    gnt_n <= #1 req_n;
    cyc <= cyc + 1;
    if (rvalid) rq.push_back(rdata_d);
    if (tgt_wr) {warea, wd, wbe} <= {area, tgt_wdata, tgt_be};
    if (tgt_rd) rd_seen <= 1;
    if (demux && par_oe && par !== 1'b0) par_bad <= 1;
    if (cyc == 4000) begin
      err_total++;
      give_verdict;
    end
  end
  //****************************************************************
  // Shared tasks
  //****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic push(input int n, input logic [31:0] base);
    int k;
    for (k = 0; k < n; k++) begin
      wvalid = 1;
      wdata = base + k;
      @(posedge ref_clk_i);
      while (!wready) @(posedge ref_clk_i);
      #1;
    end
    wvalid = 0;
  endtask
  task automatic go(input logic wr, fbb, keep, input logic [31:0] a,
                    input logic [7:0] n);
    {dma_req, dma_write, dma_fbb, dma_addr, dma_len} = {1'b1, wr, fbb, a, n};
    @(posedge ref_clk_i);
    while (ack !== 1'b1) @(posedge ref_clk_i);
    #1 if (!keep) dma_req = 0;
  endtask
  task automatic done(input int n);
    int k;
    for (k = 0; k < 60 && u_host.mw_q.size() < n; k++) @(posedge ref_clk_i);
    tick(3);
  endtask
  //****************************************************************
  // Scenarios
  //****************************************************************
  task automatic t_dma(input logic wr, input logic [1:0] pace);
    int k;
    u_host.mw_q.delete();
    u_host.wr_q.delete();
    u_host.be_q.delete();
    rq.delete();
    slow = pace;
    if (wr) push(4, 32'h1000_0000);
    go(wr, 0, 0, 32'h0000_9000, 4);
    done(1);
    chk("mst_waits", 0, u_host.mw_q[0]);
    for (k = 0; k < 4; k++) begin
      if (wr) chk("wr_word", 32'h1000_0000 + k, u_host.wr_q[k]);
      if (wr) chk("wr_be", mpp_pkg::BE_ALL, u_host.be_q[k]);
      if (!wr) chk("rd_word", 32'h5a5a_9000 + k, rq[k]);
    end
    chk("burst_len", 4, wr ? u_host.wr_q.size() : rq.size());
    $display("test dma burst write=%0d done", wr);
  endtask
  task automatic t_fbb;
    u_host.mw_q.delete();
    u_host.wr_q.delete();
    slow = 0;
    push(4, 32'h2000_0000);
    go(1, 1, 1, 32'h0000_a000, 2);
    go(1, 1, 0, 32'h0000_b000, 2);
    dma_fbb = 0;
    done(2);
    chk("fbb_first", 0, u_host.mw_q[0]);
    chk("fbb_later", 1, u_host.mw_q[1]);
    chk("fbb_word", 32'h2000_0003, u_host.wr_q[3]);
    $display("test chained bursts done");
  endtask
  task automatic t_tgt(input logic [3:0] cmd, input logic [31:0] a,
                       input logic sel, input int exw, input logic [1:0] ar);
    u_host.cpu(cmd, a, sel, rdata, w);
    tick(3);
    chk("tgt_waits", exw, w);
    if (!cmd[0] && exw != 99) chk("tgt_rd", {16'h5eed, a[15:0]}, rdata);
    if (cmd[0]) chk("tgt_wr", ~a, wd);
    if (cmd[0]) chk("tgt_area", ar, warea);
    if (cmd[0]) chk("tgt_be", mpp_pkg::BE_ALL, wbe);
    chk("tgt_rd_seen", !cmd[0] && exw != 99, rd_seen);
    rd_seen = 0;
    $display("test target cmd %h addr %h done", cmd, a);
  endtask
  task automatic t_slow_local;
    local_ready_n_n = 1;
    fork
      begin
        tick(8);
        local_ready_n_n = 0;
      end
    join_none
    u_host.cpu(4'h6, 32'h0001_0030, 0, rdata, w);
    chk("lb_held", 1, w > 5 && w < 12);
    tick(3);
    $display("test local ready hold done");
  endtask
  initial begin
    tick(10);
    rst_i = 0;
    tick(2);
    t_dma(1, 0);
    t_dma(0, 1);
    t_fbb;
    demux = 1;
    t_tgt(4'ha, 32'h0000_0010, 1, 2, 0);
    t_tgt(4'h6, 32'h0000_0040, 0, 3, 1);
    t_tgt(4'h6, 32'h0001_0020, 0, 3, 2);
    t_tgt(4'hb, 32'h0000_0014, 1, 0, 0);
    t_tgt(4'h7, 32'h0000_0044, 0, 0, 1);
    t_tgt(4'h7, 32'h0001_0024, 0, 0, 2);
    chk("par_low", 0, par_bad);
    demux = 0;
    t_tgt(4'h6, 32'h8000_0000, 0, 99, 0);
    t_tgt(4'ha, 32'h0000_0010, 0, 99, 0);
    t_slow_local;
    give_verdict;
  end
endmodule
`default_nettype wire
